// [lidm_pkg.sv]
/*
  constants for the line i/o, detector multiplex and host port block.
  assumes a 50 MHz internal master clock that the clock source selection feeds.
*/
`default_nettype none
package lidm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int PULSE_NS = 31250;
  localparam int PERIOD_NS = 203125;
  localparam int MASK_NS = 15625;
  localparam int CLOCK_FAIL_FLAG_NS = 400000;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int PERIOD_CYC = PERIOD_NS / CLK_NS;
  localparam int MASK_CYC = (MASK_NS + CLK_NS - 1) / CLK_NS;
  localparam int CLOCK_FAIL_FLAG_CYC = CLOCK_FAIL_FLAG_NS / CLK_NS;
  localparam int CS_RST_EDGES = 16;
  // ----------------------------------------------------------------
  // geometry, fields, reset values
  // ----------------------------------------------------------------
  localparam int N_CH = 4;
  localparam int N_PINS = 5;
  localparam int CLK_SRC_BIT = 4;
  localparam int MUX_EN_BIT = 7;
  localparam int MUX_POL_BIT = 6;
  localparam int STS2_BIT = 5;
  localparam logic [3:0] RST_CHAN_MASK = 4'hF;
  // ----------------------------------------------------------------
  // host port commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CHAN_MASK = 8'h4A;
  localparam logic [7:0] CMD_CLK_WR = 8'h46;
  localparam logic [7:0] CMD_CLK_RD = 8'h47;
  localparam logic [7:0] CMD_MUX_WR = 8'hC8;
  localparam logic [7:0] CMD_MUX_RD = 8'hC9;
  localparam logic [7:0] CMD_LATCH_WR = 8'h52;
  localparam logic [7:0] CMD_PIN_RD = 8'h53;
  localparam logic [7:0] CMD_DIR_WR = 8'h54;
  localparam logic [7:0] CMD_DIR_RD = 8'h55;
  localparam logic [7:0] CMD_STS_RD = 8'h57;
  typedef enum logic [1:0] {PH_CMD, PH_WDATA, PH_RDATA, PH_SKIP} lidm_phase_e;
endpackage : lidm_pkg
`default_nettype wire

// [lidm_top.sv]
/*
  line i/o pins, channel mask, clock source select and detector multiplex.
  assumes host port pins are synchronous to i_sys_clk, which is the derived master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lidm_top
  import lidm_pkg::*;
#(
  parameter int P_PERIOD_CYC = PERIOD_CYC
)(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_cs_n,
  input wire logic i_serial_data_clock,
  input wire logic i_sdi,
  input wire logic i_clock_valid,
  input wire logic [N_CH*N_PINS-1:0] i_line_io_pins,
  output logic [N_CH*N_PINS-1:0] o_line_io_out,
  output logic [N_CH*N_PINS-1:0] o_line_io_oe,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_clock_fail_flag,
  output logic o_clock_source_select,
  output logic o_detector_select_pulse,
  output logic o_detector_select_pulse_oe,
  output logic [N_CH-1:0] o_detect_status_first,
  output logic [N_CH-1:0] o_detect_status_second,
  output logic [N_CH-1:0] o_gk_debounce_in
);
  if (P_PERIOD_CYC <= PULSE_CYC + MASK_CYC || P_PERIOD_CYC >= 16384)
  begin : g_chk
    $error("period count out of range");
  end
  localparam logic [13:0] PER_C = 14'(P_PERIOD_CYC - 1);
  localparam logic [13:0] PUL_C = 14'(PULSE_CYC);
  localparam logic [13:0] MSK_C = 14'(MASK_CYC);
  localparam logic [13:0] MSK2_C = 14'(PULSE_CYC + MASK_CYC);
  localparam logic [4:0] CSR_C = 5'(CS_RST_EDGES);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // read view of a channel's pins: latch for outputs, level for inputs
  function automatic logic [N_PINS-1:0] pin_view(input logic [N_PINS-1:0] dir,
    input logic [N_PINS-1:0] lat, input logic [N_PINS-1:0] lvl);
    pin_view = (dir & lat) | (~dir & lvl);
  endfunction : pin_view

  // lowest enabled channel answers reads
  function automatic logic [1:0] first_ch(input logic [N_CH-1:0] m);
    first_ch = m[0] ? 2'd0 : m[1] ? 2'd1 : m[2] ? 2'd2 : m[3] ? 2'd3 : 2'd0;
  endfunction : first_ch

  logic rst;
  logic cs_rst;
  logic cs_q;
  logic serial_data_clock_q;
  logic [4:0] bitcnt;
  logic [7:0] sh;
  logic [7:0] cmd;
  logic [7:0] rsh;
  lidm_phase_e phase;
  logic [N_CH-1:0] chan_mask;
  logic clk_src;
  logic mux_en;
  logic mux_pol;
  logic clk_written;
  logic [N_PINS-1:0] io_lat [N_CH];
  logic [N_PINS-1:0] io_dir [N_CH];
  logic [13:0] cnt;
  logic mux_act;
  logic pulse_on;
  logic en_first;
  logic en_second;
  logic [1:0] rc;
  logic [7:0] rd_val;
  logic [7:0] wdata;
  logic wr_go;
  logic rise;
  logic cs_up;
  logic byte_end;

  assign rst = i_srst | cs_rst;
  assign rise = i_serial_data_clock & ~serial_data_clock_q & ~i_cs_n;
  assign cs_up = i_cs_n & ~cs_q;
  assign wdata = {sh[6:0], i_sdi};
  // each byte travels in its own chip select frame, so a 16 rise frame is always a reset
  assign byte_end = rise && bitcnt[2:0] == 3'h7 && bitcnt < CSR_C;
  assign wr_go = byte_end && phase == PH_WDATA;
  assign rc = first_ch(chan_mask);
  assign mux_act = clk_src & mux_en;

  // ----------------------------------------------------------------
  // host serial port
  // ----------------------------------------------------------------
  // edge capture and reset from a long chip select
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      cs_q <= 1'b1;
      serial_data_clock_q <= 1'b0;
      cs_rst <= 1'b0;
    end
    else
    begin
      cs_q <= i_cs_n;
      serial_data_clock_q <= i_serial_data_clock;
      cs_rst <= cs_up && bitcnt >= CSR_C;
    end
  end

  // read data for the command just taken
  always_comb
  begin
    rd_val = 8'h00;
    case (wdata)
      CMD_CLK_RD: rd_val[CLK_SRC_BIT] = clk_src;
      CMD_MUX_RD: rd_val = {mux_en, mux_pol, 6'h00};
      CMD_PIN_RD: rd_val = {2'b00, o_detect_status_second[rc],
        pin_view(io_dir[rc], io_lat[rc], {i_line_io_pins[rc*N_PINS+1 +: 4],
        o_detect_status_first[rc]})};
      CMD_DIR_RD: rd_val = {3'b000, io_dir[rc]};
      CMD_STS_RD: rd_val = {7'h00, o_clock_fail_flag};
      default: rd_val = 8'h00;
    endcase
  end

  // rise counter and byte shifter, cleared while chip select is high
  always_ff @(posedge i_sys_clk)
  begin
    if (rst || i_cs_n)
    begin
      bitcnt <= 5'h00;
      sh <= 8'h00;
    end
    else if (rise)
    begin
      sh <= wdata;
      if (bitcnt < CSR_C)
        bitcnt <= bitcnt + 5'h01;
    end
  end

  // command, phase and read shifter survive from the command frame to the data frame
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      phase <= PH_CMD;
      cmd <= 8'h00;
      rsh <= 8'h00;
    end
    else if (rise)
    begin
      rsh <= {rsh[6:0], 1'b0};
      if (byte_end)
      begin
        case (phase)
          PH_CMD:
          begin
            cmd <= wdata;
            rsh <= rd_val;
            case (wdata)
              CMD_CHAN_MASK, CMD_CLK_WR, CMD_MUX_WR, CMD_LATCH_WR, CMD_DIR_WR:
                phase <= PH_WDATA;
              CMD_CLK_RD, CMD_MUX_RD, CMD_PIN_RD, CMD_DIR_RD, CMD_STS_RD:
                phase <= PH_RDATA;
              default: phase <= PH_SKIP;
            endcase
          end
          default: phase <= PH_CMD;
        endcase
      end
    end
  end

  // serial output pin
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
    end
    else
    begin
      o_sdo <= rsh[7];
      o_sdo_oe <= ~i_cs_n && phase == PH_RDATA;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // global settings
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      chan_mask <= RST_CHAN_MASK;
      clk_src <= 1'b0;
      mux_en <= 1'b0;
      mux_pol <= 1'b0;
      clk_written <= 1'b0;
    end
    else if (wr_go)
    begin
      case (cmd)
        CMD_CHAN_MASK: chan_mask <= wdata[N_CH-1:0];
        CMD_CLK_WR:
        begin
          clk_src <= wdata[CLK_SRC_BIT];
          clk_written <= 1'b1;
        end
        CMD_MUX_WR:
        begin
          mux_en <= wdata[MUX_EN_BIT];
          mux_pol <= wdata[MUX_POL_BIT];
        end
        default: clk_written <= clk_written;
      endcase
    end
  end

  // per channel latches and directions, written to every enabled channel
  always_ff @(posedge i_sys_clk)
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      if (rst)
      begin
        io_lat[c] <= '0;
        io_dir[c] <= '0;
      end
      else if (wr_go && chan_mask[c])
      begin
        if (cmd == CMD_LATCH_WR)
          io_lat[c] <= wdata[N_PINS-1:0];
        if (cmd == CMD_DIR_WR)
          io_dir[c] <= wdata[N_PINS-1:0];
      end
    end
  end

  // clock fail flag, low while a clock source has been written and the clock is valid
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
      o_clock_fail_flag <= 1'b1;
    else
      o_clock_fail_flag <= ~(clk_written & i_clock_valid);
  end

  // ----------------------------------------------------------------
  // select pulse and multiplexed detector
  // ----------------------------------------------------------------
  // period counter on the master clock
  always_ff @(posedge i_sys_clk)
  begin
    if (rst || !mux_act)
      cnt <= 14'd0;
    else
      cnt <= (cnt == PER_C) ? 14'd0 : cnt + 14'd1;
  end

  assign pulse_on = mux_act && cnt < PUL_C;
  assign en_second = mux_act && cnt >= MSK_C && cnt < PUL_C;
  assign en_first = !mux_act || cnt >= MSK2_C;

  // pin outputs
  always_ff @(posedge i_sys_clk)
  begin
    if (rst)
    begin
      o_line_io_out <= '0;
      o_line_io_oe <= '0;
      o_clock_source_select <= 1'b0;
      o_detector_select_pulse <= 1'b1;
      o_detector_select_pulse_oe <= 1'b0;
    end
    else
    begin
      for (int c = 0; c < N_CH; c++)
      begin
        o_line_io_out[c*N_PINS +: N_PINS] <= io_lat[c];
        o_line_io_oe[c*N_PINS +: N_PINS] <= io_dir[c];
      end
      o_clock_source_select <= clk_src;
      o_detector_select_pulse <= ~(pulse_on ^ mux_pol);
      o_detector_select_pulse_oe <= clk_src;
    end
  end

  // detect status latches and ground key source
  always_ff @(posedge i_sys_clk)
  begin
    for (int c = 0; c < N_CH; c++)
    begin
      if (rst)
      begin
        o_detect_status_first[c] <= 1'b0;
        o_detect_status_second[c] <= 1'b0;
        o_gk_debounce_in[c] <= 1'b0;
      end
      else
      begin
        if (en_first)
          o_detect_status_first[c] <= i_line_io_pins[c*N_PINS];
        if (en_second)
          o_detect_status_second[c] <= i_line_io_pins[c*N_PINS];
        o_gk_debounce_in[c] <= mux_act ? o_detect_status_second[c]
          : i_line_io_pins[c*N_PINS+1];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [13:0] wid;
  always_ff @(posedge i_sys_clk)
  begin
    if (rst || !pulse_on)
      wid <= 14'd0;
    else
      wid <= wid + 14'd1;
  end

  sequence s_mask_write;
    wr_go && cmd == CMD_CHAN_MASK;
  endsequence
  sequence s_pulse_end;
    $fell(pulse_on) && mux_act && !rst;
  endsequence

  a_cs_reset: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    cs_up && bitcnt >= CSR_C |=> cs_rst ##1 !o_sdo_oe && chan_mask == RST_CHAN_MASK)
    else $error("long chip select did not reset");
  a_clock_fail_flag_clear: assert property (@(posedge i_sys_clk) disable iff (rst)
    !rst && clk_written && i_clock_valid |-> ##[1:2] !o_clock_fail_flag)
    else $error("clock fail flag stuck");
  a_mask_store: assert property (@(posedge i_sys_clk) disable iff (rst)
    s_mask_write |=> chan_mask == $past(wdata[3:0]))
    else $error("channel mask not stored");
  a_bcast_latch: assert property (@(posedge i_sys_clk) disable iff (rst)
    wr_go && cmd == CMD_LATCH_WR && chan_mask[3] |-> ##2 o_line_io_out[19:15] == $past(wdata[4:0], 2))
    else $error("broadcast latch write missed");
  a_pulse_width: assert property (@(posedge i_sys_clk) disable iff (rst)
    s_pulse_end |-> $past(wid) == PUL_C - 14'd1)
    else $error("select pulse width wrong");
  a_mux_gate: assert property (@(posedge i_sys_clk) disable iff (rst)
    !rst && !(clk_src && mux_en) |=> o_detector_select_pulse == ~$past(mux_pol))
    else $error("select pulse active outside multiplex");
  a_first_hold: assert property (@(posedge i_sys_clk) disable iff (rst)
    pulse_on && !rst ##1 pulse_on |-> $stable(o_detect_status_first))
    else $error("first status moved during pulse");
  a_settle_mask: assert property (@(posedge i_sys_clk) disable iff (rst)
    !rst && mux_act && cnt < MSK_C |=> $stable(o_detect_status_second))
    else $error("second status moved in settle window");
  a_gk_source: assert property (@(posedge i_sys_clk) disable iff (rst)
    !rst && !mux_act |=> o_gk_debounce_in[0] == $past(i_line_io_pins[1]))
    else $error("ground key source wrong");
endmodule : lidm_top
`default_nettype wire

// [lidm_line_model.sv]
/*
  behavioural model of four line interface circuits on the line pins.
  assumes the testbench gives the select pulse polarity and the two detect states.
*/
`timescale 1ns/1ps
`default_nettype none
module lidm_line_model
  import lidm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sel_pin,
  input wire logic i_sel_oe,
  input wire logic i_active_high,
  input wire logic [N_CH-1:0] i_loop,
  input wire logic [N_CH-1:0] i_gk,
  input wire logic [N_CH*N_PINS-1:0] i_other,
  output logic [N_CH*N_PINS-1:0] o_pins
);
  // ----------------------------------------------------------------
  // detector output
  // ----------------------------------------------------------------
  localparam int SETTLE = 300; // settling, shorter than the masked window
  logic sel;
  logic sel_q = 1'b0;
  int settle_cnt = 0;
  // the select input only counts while the pin is driven
  assign sel = i_sel_oe && (i_sel_pin === i_active_high);
  // restart settling on every select change
  always @(posedge i_sys_clk)
  begin
    sel_q <= sel;
    if (sel != sel_q)
      settle_cnt <= SETTLE;
    else if (settle_cnt > 0)
      settle_cnt <= settle_cnt - 1;
  end
  // detector wanders while settling, then shows loop or ground key state
  always_comb
  begin
    o_pins = i_other;
    for (int c = 0; c < N_CH; c++)
      o_pins[c*N_PINS] = (settle_cnt > 0) ? (settle_cnt[0] ^ c[0]) : (sel ? i_gk[c] : i_loop[c]);
  end
endmodule : lidm_line_model
`default_nettype wire

// [tb_line_io_detect_multiplexer.sv]
/*
  self-checking testbench for lidm_top: host frames, line pins, detector multiplex.
  assumes lidm_line_model stands on the line pins; inputs change at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_line_io_detect_multiplexer;
  import lidm_pkg::*;
  localparam int P = 4000;
  logic clk = 1'b0;
  logic srst, cs_n, sdc, sdi, vld, ah, sdo, sdo_oe, clock_fail_flag, css, pulse, pulse_oe;
  logic [3:0] loop, gk, st1, st2, gkin;
  logic [19:0] other, pins, out, oe;
  logic [7:0] rd;
  logic oe_rd;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int w, p, n;
  // ----------------------------------------------------------------
  // clock, design, line model
  // ----------------------------------------------------------------
  always #10 clk = ~clk;
  lidm_top #(.P_PERIOD_CYC(P)) u_dut (.i_sys_clk(clk), .i_srst(srst), .i_cs_n(cs_n),
    .i_serial_data_clock(sdc), .i_sdi(sdi), .i_clock_valid(vld), .i_line_io_pins(pins),
    .o_line_io_out(out), .o_line_io_oe(oe), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .o_clock_fail_flag(clock_fail_flag), .o_clock_source_select(css), .o_detector_select_pulse(pulse),
    .o_detector_select_pulse_oe(pulse_oe), .o_detect_status_first(st1),
    .o_detect_status_second(st2), .o_gk_debounce_in(gkin));
  lidm_line_model u_line (.i_sys_clk(clk), .i_sel_pin(pulse), .i_sel_oe(pulse_oe),
    .i_active_high(ah), .i_loop(loop), .i_gk(gk), .i_other(other), .o_pins(pins));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("mismatches=%0d total_checks=%0d", mismatches, total_checks);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one chip-select frame of nr data clock rises sending b msb first, first sdo byte collected
  task automatic byte_frame(input logic [7:0] b, input int nr);
    rd = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int k = 0; k < nr; k++)
    begin
      sdc = 1'b0;
      sdi = b[7 - (k % 8)];
      repeat (2) @(negedge clk);
      if (k == 0)
        oe_rd = sdo_oe;
      if (k < 8)
        rd[7 - k] = sdo;
      sdc = 1'b1;
      repeat (2) @(negedge clk);
    end
    sdc = 1'b0;
    repeat (2) @(negedge clk);
    cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : byte_frame
  // command byte and data byte each in a frame of their own
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    byte_frame(cmd, 8);
    byte_frame(dat, 8);
  endtask : wr
  // read: command frame, then a frame that clocks the answer out of this single device
  task automatic rdc(input logic [7:0] cmd);
    byte_frame(cmd, 8);
    byte_frame(8'h00, 8);
  endtask : rdc
  // cycles until the select pin shows lv, bounded
  task automatic wait_lvl(input logic lv, output int c);
    c = 0;
    while (pulse !== lv && c < 6000)
    begin
      @(negedge clk);
      c++;
    end
  endtask : wait_lvl
  // count status changes over the 700 cycles after a pulse edge
  task automatic still(output int c);
    logic [3:0] a, b;
    a = st1;
    b = st2;
    c = 0;
    repeat (700)
    begin
      @(negedge clk);
      if (st1 !== a || st2 !== b)
        c++;
    end
  endtask : still
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    chk(out, 20'h0);
    chk(oe, 20'h0);
    chk(clock_fail_flag, 1'b1);
    chk(css, 1'b0);
    chk(pulse_oe, 1'b0);
  endtask : t_reset_values
  // clock selected first, no channel activated meanwhile
  task automatic t_clock_select();
    wr(CMD_CLK_WR, 8'h10);
    repeat (2) @(negedge clk);
    chk(css, 1'b1);
    chk(pulse_oe, 1'b1);
    chk(clock_fail_flag, 1'b0);
    rdc(CMD_CLK_RD);
    chk(rd[4], 1'b1);
    chk(oe_rd, 1'b1);
    chk(sdo_oe, 1'b0);
    rdc(CMD_STS_RD);
    chk(rd[0], 1'b0);
    vld = 1'b0;
    repeat (3) @(negedge clk);
    chk(clock_fail_flag, 1'b1);
    vld = 1'b1;
    repeat (3) @(negedge clk);
    chk(clock_fail_flag, 1'b0);
  endtask : t_clock_select
  // latches loaded before directions turn to output
  task automatic t_mask_latch();
    wr(CMD_CHAN_MASK, 8'h0F);
    wr(CMD_LATCH_WR, 8'h15);
    chk(out, {4{5'h15}});
    chk(oe, 20'h0);
    wr(CMD_CHAN_MASK, 8'h02);
    wr(CMD_DIR_WR, 8'h0A);
    chk(oe, 20'h00140);
    rdc(CMD_DIR_RD);
    chk(rd, 8'h0A);
    wr(CMD_CHAN_MASK, 8'h09);
    wr(CMD_LATCH_WR, 8'h0B);
    chk(out, {5'h0B, 5'h15, 5'h15, 5'h0B});
  endtask : t_mask_latch
  task automatic t_pin_read();
    wr(CMD_CHAN_MASK, 8'h02);
    loop = 4'h2;
    other = 20'h001C0;
    repeat (3) @(negedge clk);
    rdc(CMD_PIN_RD);
    chk(rd[4:0], 5'h05);
    loop = 4'h0;
    other = 20'h0;
    repeat (3) @(negedge clk);
    rdc(CMD_PIN_RD);
    chk(rd[4:0], 5'h00);
  endtask : t_pin_read
  task automatic t_mux();
    loop = 4'hA;
    gk = 4'h6;
    other = 20'h10002;
    repeat (3) @(negedge clk);
    chk(gkin, 4'h9);
    chk(st1, 4'hA);
    wr(CMD_MUX_WR, 8'h80);
    wait_lvl(1'b0, w);
    wait_lvl(1'b1, w);
    wait_lvl(1'b0, p);
    still(n);
    chk(n, 0);
    repeat (200) @(negedge clk);
    chk(st2, 4'h6);
    chk(gkin, 4'h6);
    gk = 4'h3;
    repeat (5) @(negedge clk);
    chk(st2, 4'h3);
    chk(st1, 4'hA);
    wait_lvl(1'b1, w);
    still(n);
    chk(n, 0);
    repeat (1000) @(negedge clk);
    loop = 4'h5;
    gk = 4'hC;
    repeat (5) @(negedge clk);
    chk(st1, 4'h5);
    chk(st2, 4'h3);
    wait_lvl(1'b0, p);
    wait_lvl(1'b1, w);
    wait_lvl(1'b0, p);
    chk(w, PULSE_CYC);
    chk(w + p, P);
    wr(CMD_MUX_WR, 8'hC0);
    rdc(CMD_MUX_RD);
    chk(rd, 8'hC0);
    ah = 1'b1;
    wait_lvl(1'b0, w);
    wait_lvl(1'b1, w);
    wait_lvl(1'b0, w);
    chk(w, PULSE_CYC);
    wr(CMD_MUX_WR, 8'h40);
    repeat (5) @(negedge clk);
    chk(pulse, 1'b0);
    chk(gkin, 4'h9);
    ah = 1'b0;
    wr(CMD_CLK_WR, 8'h00);
    wr(CMD_MUX_WR, 8'h80);
    n = 0;
    repeat (P + 100)
    begin
      @(negedge clk);
      if (pulse !== 1'b1)
        n++;
    end
    chk(n, 0);
    chk(pulse_oe, 1'b0);
  endtask : t_mux
  task automatic t_cs_reset();
    wr(CMD_CLK_WR, 8'h10);
    chk(css, 1'b1);
    byte_frame(CMD_CLK_RD, CS_RST_EDGES);
    repeat (3) @(negedge clk);
    chk(css, 1'b0);
    chk(clock_fail_flag, 1'b1);
    chk(out, 20'h0);
  endtask : t_cs_reset
  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    srst = 1'b1;
    cs_n = 1'b1;
    sdc = 1'b0;
    sdi = 1'b0;
    vld = 1'b1;
    ah = 1'b0;
    loop = 4'h0;
    gk = 4'h0;
    other = 20'h0;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    t_reset_values();
    t_clock_select();
    t_mask_latch();
    t_pin_read();
    t_mux();
    t_cs_reset();
    print_verdict();
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      $display("[FAIL] %0t run exceeded its cycle budget", $time);
      print_verdict();
    end
  end
endmodule : tb_line_io_detect_multiplexer
`default_nettype wire
